// ### src/uidt_regs.svh
// Register offsets, field positions and reset values of the UART irq/dma/test block
`ifndef UIDT_REGS_SVH
`define UIDT_REGS_SVH

// Byte offsets on the register bus
`define UIDT_OFS_RAW      8'h3C
`define UIDT_OFS_MASK     8'h38
`define UIDT_OFS_MIS      8'h40
`define UIDT_OFS_CLEAR    8'h44
`define UIDT_OFS_DMA      8'h48
`define UIDT_OFS_TCTL     8'h80
`define UIDT_OFS_TIN      8'h84
`define UIDT_OFS_TDATA    8'h8C

// Interrupt bit positions, shared by raw, mask, masked and clear
`define UIDT_BIT_OVERRUN  10
`define UIDT_BIT_BREAK    9
`define UIDT_BIT_PARITY   8
`define UIDT_BIT_FRAMING  7
`define UIDT_BIT_TIMEOUT  6
`define UIDT_BIT_TX       5
`define UIDT_BIT_RX       4
`define UIDT_BIT_CTS      1

// Implemented interrupt bits and the error group
`define UIDT_SUP_BITS     11'h7F2
`define UIDT_ERR_BITS     11'h780

// DMA control fields
`define UIDT_DMA_GATE     2
`define UIDT_DMA_TXEN     1
`define UIDT_DMA_RXEN     0

// Test control fields
`define UIDT_TC_FIFO      1
`define UIDT_TC_ITEST     0

// Test input readback fields
`define UIDT_TIN_CTS      3
`define UIDT_TIN_RXD      0

// Reset values
`define UIDT_RST_IRQ      11'h000
`define UIDT_RST_DMA      3'h0
`define UIDT_RST_TCTL     2'h0
`define UIDT_RST_WORD     32'h0000_0000
`define UIDT_RST_TDATA    11'h000

`endif

// ### src/uidt_pkg.sv
// Types shared by the UART irq/dma/test block
`default_nettype none

package uidt_pkg;

  typedef logic [31:0] uidt_word_t;
  typedef logic [10:0] uidt_irq_t;
  typedef logic [10:0] uidt_tdata_t;

  // Whole register state of the control block
  typedef struct packed {
    logic        ack;
    uidt_word_t  dat;
    uidt_irq_t   raw;
    uidt_irq_t   mask;
    logic [2:0]  dma;
    logic [1:0]  tctl;
    logic        irq;
    logic        tx_req;
    logic        rx_req;
    logic        push;
    uidt_tdata_t push_data;
    logic        pop;
    logic        itest;
  } uidt_state_s;

endpackage

`default_nettype wire

// ### src/uidt_sync2.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module uidt_sync2 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Pin side and clean side
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  // Both stages live in one packed state word
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] clean;
  } uidt_sync_s;

  uidt_sync_s st_q;
  uidt_sync_s st_d;

  // First stage feeds only the second stage
  always_comb
  begin
    st_d       = st_q;
    st_d.meta  = async_in;
    st_d.clean = st_q.meta;
  end

  // Registered stages, cleared on reset
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.clean;

endmodule // uidt_sync2

`default_nettype wire

// ### src/uidt_ctrl.sv
// UART interrupt status, DMA request control and integration test registers
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "uidt_regs.svh"

//
// Contract
// R1: Masked overrun status at bit 10
// R2: Masked break, parity, framing at 9,8,7
// R3: Masked timeout, tx, rx at 6,5,4
// R4: Masked clear-to-send status at bit 1
// R5: Status clears on reset, modem bits undefined
// R6: Clear bits 10..7 clear error interrupts
// R7: Clear bits 6..4 clear timeout, tx, rx
// R8: Clear bit 1 clears clear-to-send interrupt
// R9: Software writes zero to unused modem bits
// R10: Gate bit blocks rx requests during error
// R11: Tx requests only while tx enable set
// R12: Rx requests only while rx enable set
// R13: Fifo test: write pushes rx, read pops tx
// R14: Without fifo test, no direct fifo path
// R15: Test bit 0 selects integration test mode
// R16: Test input bit 3 shows cts pin
// R17: Test input bit 0 shows rx pin
// R18: Mask bits written; masked equals raw and mask
// R19: Raw status bit per interrupt, before masking
// R20: Writing zero to clear leaves state alone
// R21: Combined interrupt is OR of masked bits
module uidt_ctrl (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // Wishbone classic slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire uidt_pkg::uidt_word_t wb_dat_i,
  output var  uidt_pkg::uidt_word_t wb_dat_o,
  output var  logic               wb_ack_o,
  // Interrupt events from the UART core, one-cycle pulses
  input  wire logic               overrun_irq,
  input  wire logic               break_irq,
  input  wire logic               parity_irq,
  input  wire logic               framing_irq,
  input  wire logic               timeout_irq,
  input  wire logic               tx_irq,
  input  wire logic               rx_irq,
  input  wire logic               cts_change_irq,
  // Primary input pins, asynchronous
  input  wire logic               clear_to_send_in_n,
  input  wire logic               serial_rx_in,
  // FIFO request levels from the FIFO logic
  input  wire logic               tx_fifo_dma_want,
  input  wire logic               rx_fifo_dma_want,
  // Transmit FIFO head, for test reads
  input  wire uidt_pkg::uidt_tdata_t tx_fifo_head,
  // DMA requests to the DMA controller
  output var  logic               tx_dma_req,
  output var  logic               rx_dma_req,
  // Combined interrupt to the interrupt controller
  output var  logic               irq_combined,
  // Direct FIFO access in fifo test mode
  output var  logic               rx_fifo_push,
  output var  uidt_pkg::uidt_tdata_t rx_fifo_push_data,
  output var  logic               tx_fifo_pop,
  // Mode flags to the rest of the UART
  output var  logic               integration_test_mode,
  output var  logic               test_fifo_mode
);

  import uidt_pkg::*;

  uidt_state_s st_q;
  uidt_state_s st_d;

  // Synchronised pin levels
  logic [1:0] pins_sync;

  // Bus decode helpers
  logic       access;
  logic       wr;
  logic       rd;
  logic [7:0] word_adr;
  uidt_irq_t  bmask;
  uidt_irq_t  wbits;
  uidt_irq_t  events;
  uidt_irq_t  clr;
  uidt_irq_t  masked;
  logic       err_active;
  uidt_word_t rdata;

  // Pins come from outside the clock domain
  uidt_sync2 #(
    .W(2)
  ) u_pin_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in ({clear_to_send_in_n, serial_rx_in}),
    .sync_out (pins_sync)
  );

  // Gather event pulses into status bit positions
  always_comb
  begin
    events                    = '0;
    events[`UIDT_BIT_OVERRUN] = overrun_irq;
    events[`UIDT_BIT_BREAK]   = break_irq;
    events[`UIDT_BIT_PARITY]  = parity_irq;
    events[`UIDT_BIT_FRAMING] = framing_irq;
    events[`UIDT_BIT_TIMEOUT] = timeout_irq;
    events[`UIDT_BIT_TX]      = tx_irq;
    events[`UIDT_BIT_RX]      = rx_irq;
    events[`UIDT_BIT_CTS]     = cts_change_irq;
  end

  // Bus request qualification; ack drops the cycle after it rose
  always_comb
  begin
    access   = wb_cyc_i & wb_stb_i & ~st_q.ack;
    wr       = access & wb_we_i;
    rd       = access & ~wb_we_i;
    word_adr = {wb_adr_i[7:2], 2'h0};
    // Only lanes 0 and 1 carry the 11 live bits
    bmask    = {{3{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wbits    = wb_dat_i[10:0] & bmask;
  end

  // Masked view and error group
  always_comb
  begin
    masked     = st_q.raw & st_q.mask;         // [R18] [R1] [R2] [R3] [R4]
    err_active = |(masked & `UIDT_ERR_BITS);
  end

  // Clear strobe: only written ones clear, zeros leave state
  always_comb
  begin
    clr = '0;
    if (wr && (word_adr == `UIDT_OFS_CLEAR))
    begin
      clr = wbits & `UIDT_SUP_BITS;            // [R6] [R7] [R8] [R20]
    end
  end

  // Read data mux; reserved and unused modem bits read zero
  always_comb
  begin
    rdata = `UIDT_RST_WORD;
    unique case (word_adr)
      `UIDT_OFS_RAW:
      begin
        rdata[10:0] = st_q.raw;                // [R19]
      end
      `UIDT_OFS_MASK:
      begin
        rdata[10:0] = st_q.mask;               // [R18]
      end
      `UIDT_OFS_MIS:
      begin
        rdata[10:0] = masked;                  // [R1] [R2] [R3] [R4]
      end
      `UIDT_OFS_DMA:
      begin
        rdata[2:0] = st_q.dma;
      end
      `UIDT_OFS_TCTL:
      begin
        rdata[1:0] = st_q.tctl;
      end
      `UIDT_OFS_TIN:
      begin
        rdata[`UIDT_TIN_CTS] = pins_sync[1];   // [R16]
        rdata[`UIDT_TIN_RXD] = pins_sync[0];   // [R17]
      end
      `UIDT_OFS_TDATA:
      begin
        // Without fifo test the transmit FIFO is not visible
        if (st_q.tctl[`UIDT_TC_FIFO])
        begin
          rdata[10:0] = tx_fifo_head;          // [R13] [R14]
        end
      end
      default:
      begin
        // Clear register is write-only, unmapped reads give zero
        rdata = `UIDT_RST_WORD;
      end
    endcase
  end

  // Next-state logic for the whole block
  always_comb
  begin
    st_d        = st_q;
    st_d.ack    = access;
    st_d.dat    = rd ? rdata : `UIDT_RST_WORD;
    st_d.push   = 1'b0;
    st_d.pop    = 1'b0;

    // A new event wins over a clear in the same cycle
    st_d.raw = ((st_q.raw & ~clr) | events) & `UIDT_SUP_BITS; // [R19] [R6] [R7] [R8]

    if (wr)
    begin
      unique case (word_adr)
        `UIDT_OFS_MASK:
        begin
          // Unused modem mask bits stay zero
          st_d.mask = ((st_q.mask & ~bmask) | wbits) & `UIDT_SUP_BITS; // [R18]
        end
        `UIDT_OFS_DMA:
        begin
          if (wb_sel_i[0])
          begin
            st_d.dma = wb_dat_i[2:0];
          end
        end
        `UIDT_OFS_TCTL:
        begin
          if (wb_sel_i[0])
          begin
            st_d.tctl = wb_dat_i[1:0];
          end
        end
        `UIDT_OFS_TDATA:
        begin
          // Writes outside fifo test mode are dropped
          if (st_q.tctl[`UIDT_TC_FIFO] && wb_sel_i[0])
          begin
            st_d.push      = 1'b1;             // [R13] [R14]
            st_d.push_data = wb_dat_i[10:0];
          end
        end
        default:
        begin
          // Read-only and unmapped writes change no storage; clear writes act only on raw
          st_d.dma = st_q.dma;
        end
      endcase
    end

    // Pop the transmit head once per test read
    if (rd && (word_adr == `UIDT_OFS_TDATA) && st_q.tctl[`UIDT_TC_FIFO])
    begin
      st_d.pop = 1'b1;                         // [R13]
    end

    // Combined interrupt, one cycle behind the masked view
    st_d.irq = |masked;                        // [R21]

    // Transmit requests only with the transmit enable
    st_d.tx_req = st_q.dma[`UIDT_DMA_TXEN] & tx_fifo_dma_want; // [R11]

    // Receive requests gated by enable and, optionally, errors
    st_d.rx_req = st_q.dma[`UIDT_DMA_RXEN] & rx_fifo_dma_want  // [R12]
                & ~(st_q.dma[`UIDT_DMA_GATE] & err_active);    // [R10]

    // Mode flag for the test multiplexors elsewhere
    st_d.itest = st_q.tctl[`UIDT_TC_ITEST];    // [R15]
  end

  // State register; all status cleared on reset
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_q.ack       <= 1'b0;
      st_q.dat       <= `UIDT_RST_WORD;
      st_q.raw       <= `UIDT_RST_IRQ;         // [R5]
      st_q.mask      <= `UIDT_RST_IRQ;
      st_q.dma       <= `UIDT_RST_DMA;
      st_q.tctl      <= `UIDT_RST_TCTL;
      st_q.irq       <= 1'b0;
      st_q.tx_req    <= 1'b0;
      st_q.rx_req    <= 1'b0;
      st_q.push      <= 1'b0;
      st_q.push_data <= `UIDT_RST_TDATA;
      st_q.pop       <= 1'b0;
      st_q.itest     <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Every output comes straight from the state register
  assign wb_ack_o              = st_q.ack;
  assign wb_dat_o              = st_q.dat;
  assign irq_combined          = st_q.irq;
  assign tx_dma_req            = st_q.tx_req;
  assign rx_dma_req            = st_q.rx_req;
  assign rx_fifo_push          = st_q.push;
  assign rx_fifo_push_data     = st_q.push_data;
  assign tx_fifo_pop           = st_q.pop;
  assign integration_test_mode = st_q.itest;
  assign test_fifo_mode        = st_q.tctl[`UIDT_TC_FIFO];

endmodule // uidt_ctrl

`default_nettype wire

// ### testbench/uidt_ctrl_assertions.sv
// Port-level checks on the irq/dma/test block
`timescale 1ns/1ps
`default_nettype none
`include "uidt_regs.svh"

module uidt_ctrl_chk (
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // FIFO and DMA side
  input wire logic        tx_fifo_dma_want,
  input wire logic        rx_fifo_dma_want,
  input wire logic [10:0] tx_fifo_head,
  input wire logic        tx_dma_req,
  input wire logic        rx_dma_req,
  input wire logic        rx_fifo_push,
  input wire logic [10:0] rx_fifo_push_data,
  input wire logic        tx_fifo_pop,
  // Mode flags
  input wire logic        integration_test_mode,
  input wire logic        test_fifo_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // Bus answer one edge after the take, one cycle wide, data quiet otherwise
  AST_ACK_NEXT:
    assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("no ack");
  AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  AST_DAT_IDLE:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data not idle");
  // A request only follows a FIFO that wanted one
  AST_TX_REQ:
    assert property (tx_dma_req |-> $past(tx_fifo_dma_want)) else $error("tx req unwanted");
  AST_RX_REQ:
    assert property (rx_dma_req |-> $past(rx_fifo_dma_want)) else $error("rx req unwanted");
  // Direct FIFO access only in fifo test mode, tied to the bus cycle
  AST_NO_PUSH:
    assert property (rx_fifo_push |-> test_fifo_mode && wb_ack_o && $past(wb_we_i))
    else $error("push outside test");
  AST_PUSH_DATA:
    assert property (rx_fifo_push |-> rx_fifo_push_data == $past(wb_dat_i[10:0]))
    else $error("push data");
  AST_POP:
    assert property (tx_fifo_pop |-> test_fifo_mode && wb_ack_o && !$past(wb_we_i)
      && $past(wb_adr_i) == `UIDT_OFS_TDATA) else $error("stray pop");
  AST_POP_DATA:
    assert property (tx_fifo_pop |-> wb_dat_o[10:0] == $past(tx_fifo_head))
    else $error("pop data");
  // Mode flags follow a test control write within two edges
  AST_ITEST:
    assert property ((wb_ack_o && $past(wb_we_i) && $past(wb_sel_i[0])
      && $past(wb_adr_i) == `UIDT_OFS_TCTL) |=> integration_test_mode == $past(wb_dat_i[0], 2)
      && test_fifo_mode == $past(wb_dat_i[1], 2)) else $error("test mode flags");
endmodule // uidt_ctrl_chk

bind uidt_ctrl uidt_ctrl_chk uidt_ctrl_chk_i (
  .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .tx_fifo_dma_want(tx_fifo_dma_want),
  .rx_fifo_dma_want(rx_fifo_dma_want), .tx_fifo_head(tx_fifo_head), .tx_dma_req(tx_dma_req),
  .rx_dma_req(rx_dma_req), .rx_fifo_push(rx_fifo_push), .rx_fifo_push_data(rx_fifo_push_data),
  .tx_fifo_pop(tx_fifo_pop), .integration_test_mode(integration_test_mode),
  .test_fifo_mode(test_fifo_mode));
`default_nettype wire

// ### testbench/uidt_far_model.sv
// FIFO and DMA side stand-in for the irq/dma/test block
`timescale 1ns/1ps
`default_nettype none

module uidt_far_model (
  // Clock, reset and bench control
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        stall,
  // FIFO side of the block
  input  wire logic        tx_fifo_pop,
  input  wire logic        rx_fifo_push,
  input  wire logic [10:0] rx_fifo_push_data,
  output logic             tx_fifo_dma_want,
  output logic             rx_fifo_dma_want,
  output logic [10:0]      tx_fifo_head,
  // What arrived
  output logic [10:0]      last_push,
  output logic [7:0]       push_count
);
  // Wants stay up unless the bench stalls the FIFOs
  assign tx_fifo_dma_want = !stall;
  assign rx_fifo_dma_want = !stall;

  // Odd step on each pop, so a missed or double pop shows in the data
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tx_fifo_head <= 11'h2A5;
      last_push <= 11'h000;
      push_count <= 8'h00;
    end
    else
    begin
      if (tx_fifo_pop) tx_fifo_head <= tx_fifo_head + 11'h13B;
      if (rx_fifo_push) last_push <= rx_fifo_push_data;
      if (rx_fifo_push) push_count <= push_count + 8'h01;
    end
  end
endmodule // uidt_far_model
`default_nettype wire

// ### testbench/test_uart_irq_dma_test_control.sv
// Self-checking bench for the irq/dma/test block
`timescale 1ns/1ps
`default_nettype none
`include "uidt_regs.svh"

module test_uart_irq_dma_test_control;
  logic        clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, stall = 0, cts_n = 1, rxd = 1;
  logic [7:0]  adr = '0, ev = '0, pc;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wd = '0, rd, m, q[$];
  logic [10:0] head, pd, lp;
  logic        ack, twant, rwant, txr, rxr, irq, push, pop, itm, tfm;
  logic [7:0]  ofs[7] = '{8'h3C, 8'h38, 8'h40, 8'h44, 8'h48, 8'h80, 8'h10};
  int          err_count = 0, num_checks = 0;

  always #2 clk = ~clk;

  uidt_ctrl uidt_ctrl_i (
    .clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .overrun_irq(ev[7]), .break_irq(ev[6]), .parity_irq(ev[5]), .framing_irq(ev[4]),
    .timeout_irq(ev[3]), .tx_irq(ev[2]), .rx_irq(ev[1]), .cts_change_irq(ev[0]),
    .clear_to_send_in_n(cts_n), .serial_rx_in(rxd), .tx_fifo_dma_want(twant),
    .rx_fifo_dma_want(rwant), .tx_fifo_head(head), .tx_dma_req(txr), .rx_dma_req(rxr),
    .irq_combined(irq), .rx_fifo_push(push), .rx_fifo_push_data(pd), .tx_fifo_pop(pop),
    .integration_test_mode(itm), .test_fifo_mode(tfm));
  uidt_far_model uidt_far_model_i (
    .clk(clk), .resetn(resetn), .stall(stall), .tx_fifo_pop(pop), .rx_fifo_push(push),
    .rx_fifo_push_data(pd), .tx_fifo_dma_want(twant), .rx_fifo_dma_want(rwant),
    .tx_fifo_head(head), .last_push(lp), .push_count(pc));

  // Event vector to interrupt bit positions; cts sits alone at bit 1
  function automatic logic [31:0] bits(input logic [7:0] v);
    return {21'h0, v[7:1], 2'h0, v[0], 1'h0};
  endfunction

  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask

  // One classic cycle; a read leaves its expected word for the monitor
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    if (!w) q.push_back(d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    if (n >= 40) ck(0, 1);
    cyc <= 0;
    stb <= 0;
  endtask

  // One-cycle event, then time for raw, masked and combined to settle
  task pulse(input logic [7:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= '0;
    repeat (3) @(posedge clk);
  endtask

  // Read answers compared with the oldest note
  always @(posedge clk)
    if (ack === 1'b1 && !we)
      ck(rd, q.size() ? q.pop_front() : 32'hDEAD_BEEF);

  initial
  begin
    void'($urandom(86285));
    repeat (10) @(posedge clk);
    resetn <= 1;
    repeat (3) @(posedge clk);
    // Reset values, write-only clear and an unmapped place all read zero
    foreach (ofs[i]) bus(0, ofs[i], 32'h0);
    bus(1, `UIDT_OFS_MASK, 32'h7F2);
    for (int i = 0; i < 8; i++)
    begin
      m = bits(8'h01 << i);
      pulse(8'h01 << i);
      bus(0, `UIDT_OFS_MIS, m);
      ck(irq, 1);
      bus(1, `UIDT_OFS_CLEAR, m ^ 32'h7F2);
      bus(0, `UIDT_OFS_MIS, m);
      bus(1, `UIDT_OFS_CLEAR, m);
      bus(0, `UIDT_OFS_MIS, 32'h0);
      ck(irq, 0);
    end
    // Event and clear taken at one edge: the event wins
    fork
      bus(1, `UIDT_OFS_CLEAR, 32'h400);
      pulse(8'h80);
    join
    bus(0, `UIDT_OFS_MIS, 32'h400);
    bus(1, `UIDT_OFS_CLEAR, 32'h400);
    // Random mask over every raw event
    m = $urandom & 32'h7F2;
    bus(1, `UIDT_OFS_MASK, m);
    bus(0, `UIDT_OFS_MASK, m);
    pulse(8'hFF);
    bus(0, `UIDT_OFS_RAW, 32'h7F2);
    bus(0, `UIDT_OFS_MIS, m);
    ck(irq, |m);
    // Mid-run reset drops pending status and the combined line
    @(posedge clk);
    resetn <= 0;
    repeat (2) @(posedge clk);
    resetn <= 1;
    repeat (3) @(posedge clk);
    bus(0, `UIDT_OFS_RAW, 32'h0);
    bus(0, `UIDT_OFS_MIS, 32'h0);
    ck(irq, 0);
    // All DMA enables, with a masked overrun pending and FIFOs stalled or not
    bus(1, `UIDT_OFS_MASK, 32'h400);
    pulse(8'h80);
    for (int v = 0; v < 16; v++)
    begin
      stall <= v[3];
      bus(1, `UIDT_OFS_DMA, v);
      repeat (2) @(posedge clk);
      ck(txr, v[1] & !v[3]);
      ck(rxr, v[0] & !v[3] & !v[2]);
    end
    // FIFOs want again, so only the gate could hold the receive request
    stall <= 0;
    bus(1, `UIDT_OFS_CLEAR, 32'h7F2);
    bus(0, `UIDT_OFS_DMA, 32'h7);
    ck(rxr, 1);
    // Test data port with fifo test off has no effect
    bus(1, `UIDT_OFS_TDATA, 32'h5A5);
    bus(0, `UIDT_OFS_TDATA, 32'h0);
    ck({pc, head}, {8'h00, 11'h2A5});
    bus(1, `UIDT_OFS_TCTL, 32'h1);
    repeat (2) @(posedge clk);
    ck({itm, tfm}, 2'h2);
    bus(1, `UIDT_OFS_TCTL, 32'h2);
    bus(0, `UIDT_OFS_TCTL, 32'h2);
    ck({itm, tfm}, 2'h1);
    // Back-to-back push and pop through the test data port
    for (int k = 0; k < 3; k++)
    begin
      m = $urandom & 32'h7FF;
      bus(1, `UIDT_OFS_TDATA, m);
      // Expected head follows the model's step, so a double pop shows
      bus(0, `UIDT_OFS_TDATA, 32'(11'(11'h2A5 + 11'h13B * 11'(k))));
      ck(lp, m);
    end
    ck(pc, 3);
    // Every pin combination, after the synchroniser has settled
    for (int p = 0; p < 4; p++)
    begin
      {cts_n, rxd} <= p[1:0];
      repeat (6) @(posedge clk);
      bus(0, `UIDT_OFS_TIN, {28'h0, cts_n, 2'h0, rxd});
    end
    repeat (2) @(posedge clk);
    end_sim;
  end

  // Run needs about four hundred cycles; a hang ends here
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim;
  end

  task end_sim;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
endmodule // test_uart_irq_dma_test_control
`default_nettype wire
